//--- inc/mcx_pkg.sv
/*
 * Shared constants for the execute-subset datapath: register offsets,
 * field positions, flag bit positions, reset values, opcodes and states.
 * Assumes every design file imports it whole.
 */
package mcx_pkg;
	// Register byte offsets on the bus
	localparam logic [7:0] MCX_OFF_ACC = 8'h00;
	localparam logic [7:0] MCX_OFF_STATUS = 8'h04;
	localparam logic [7:0] MCX_OFF_PTR_LO = 8'h08;
	localparam logic [7:0] MCX_OFF_PTR_HI = 8'h0C;
	localparam logic [7:0] MCX_OFF_FETCH_HI = 8'h10;
	localparam logic [7:0] MCX_OFF_OPND = 8'h14;
	localparam logic [7:0] MCX_OFF_CMD = 8'h18;
	localparam logic [7:0] MCX_OFF_EXST = 8'h1C;
	localparam logic [7:0] MCX_OFF_MADDR = 8'h20;
	localparam logic [7:0] MCX_OFF_MDATA = 8'h24;
	localparam logic [7:0] MCX_OFF_BANK = 8'h28;
	// Operand register field positions
	localparam int MCX_OPND_ADDR_LSB = 0;
	localparam int MCX_OPND_IMM_LSB = 16;
	localparam int MCX_OPND_BIT_LSB = 24;
	// Widths
	localparam int MCX_DM_AW = 11;
	localparam int MCX_BANK_W = 3;
	// Flag bit positions in the status register
	localparam int MCX_FLG_C = 0;
	localparam int MCX_FLG_HALF = 1;
	localparam int MCX_FLG_Z = 2;
	localparam int MCX_FLG_WRAP = 3;
	localparam int MCX_FLG_SIGN = 4;
	localparam int MCX_FLG_CHAIN = 5;
	// Flag groups touched by each class of instruction
	localparam logic [5:0] MCX_MASK_SUB = 6'h3F;
	localparam logic [5:0] MCX_MASK_ADD = 6'h1F;
	localparam logic [5:0] MCX_MASK_ZERO = 6'h04;
	localparam logic [5:0] MCX_MASK_NONE = 6'h00;
	// Reset values
	localparam logic [7:0] MCX_RST_BYTE = 8'h00;
	localparam logic [5:0] MCX_RST_FLAGS = 6'h00;
	localparam logic [7:0] MCX_ZERO_BYTE = 8'h00;
	// High byte of the last program memory page
	localparam logic [7:0] MCX_LAST_PAGE = 8'hFF;
	// Wait states inserted on every bus read
	localparam logic [1:0] MCX_RD_WAIT = 2'h2;

	// Instruction codes written to the command register
	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_DIFF_MEM = 5'h01, OP_DIFF_IMM = 5'h02,
		OP_NIB_MEM = 5'h03, OP_NIB_ACC = 5'h04, OP_SKZ_BYTE = 5'h05,
		OP_SKZ_COPY = 5'h06, OP_SKZ_BIT = 5'h07, OP_TB_PAGE = 5'h08,
		OP_TB_LAST = 5'h09, OP_TB_PAGE_INC = 5'h0A, OP_TB_LAST_INC = 5'h0B,
		OP_XR_ACC = 5'h0C, OP_XR_MEM = 5'h0D, OP_XR_IMM = 5'h0E,
		OP_FA_ADC = 5'h0F, OP_FA_ADC_MEM = 5'h10, OP_FA_ADD = 5'h11,
		OP_FA_ADD_MEM = 5'h12, OP_FA_AND = 5'h13, OP_FA_AND_MEM = 5'h14,
		OP_FA_ZERO = 5'h15, OP_FA_ZERO_BIT = 5'h16
	} mcx_op_t;

	// Execution sequencer states, one-hot
	typedef enum logic [6:0] {
		S_IDLE = 7'b0000001, S_FETCH = 7'b0000010, S_EXEC = 7'b0000100,
		S_TAB = 7'b0001000, S_TWAIT = 7'b0010000, S_TWR = 7'b0100000,
		S_SKIP = 7'b1000000
	} mcx_state_t;
endpackage

//--- hw/mcx_addsub.sv
/*
 * Eight-bit adder/subtractor with the arithmetic flags.
 * Assumes purely combinational use inside the execute datapath.
 */
`timescale 1ns/1ps
`default_nettype none
module mcx_addsub (
	// Operands
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	input wire logic sub,
	// Result and flags
	output logic [7:0] res,
	output logic c,
	output logic half,
	output logic wrap,
	output logic z,
	output logic sgn
);
	import mcx_pkg::*;
	logic [7:0] bx; // Inverted operand when subtracting
	logic [8:0] full; // Sum with carry out
	logic [4:0] low; // Low nibble sum for half carry

	// Subtract as a + ~b + 1, so carry out means no borrow
	assign bx = sub ? ~b : b;
	assign full = {1'b0, a} + {1'b0, bx} + {8'h00, cin};
	assign low = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
	assign res = full[7:0];
	assign c = full[8];
	assign half = low[4];
	// Overflow when like-signed operands give an unlike-signed result
	assign wrap = (a[7] == bx[7]) && (res[7] != a[7]);
	assign z = (res == MCX_ZERO_BYTE);
	assign sgn = wrap ^ res[7];
endmodule // mcx_addsub
`default_nettype wire

//--- hw/mcx_dmem.sv
/*
 * Data memory of 2048 bytes, one port, registered read data.
 * Assumes address and write strobe come from one owner per cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module mcx_dmem (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Access port
	input wire logic we,
	input wire logic [mcx_pkg::MCX_DM_AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	import mcx_pkg::*;
	logic [7:0] mem [0:(1<<MCX_DM_AW)-1]; // Storage, no reset

	// Write port
	always_ff @(posedge hclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	// Read is old data on a same-cycle write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata <= MCX_RST_BYTE;
		end else begin
			rdata <= mem[addr];
		end
	end
endmodule // mcx_dmem
`default_nettype wire

//--- hw/mcx_exec.sv
/*
 * Execute datapath for a subset of an 8-bit core's instructions, with
 * accumulator, flags, table pointers, data memory and an AHB-Lite slave.
 * Assumes a single AHB-Lite master and a synchronous program memory that
 * returns a word the cycle after its read strobe is seen.
 */
`timescale 1ns/1ps
`default_nettype none
module mcx_exec (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Program memory read port
	output logic [15:0] pm_addr,
	output logic pm_rd,
	input wire logic [15:0] pm_rdata,
	// Execution status
	output logic exec_busy,
	output logic exec_skip
);
	import mcx_pkg::*;

	// True when a captured address hits a register offset
	function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] off);
		reg_hit = (a == {24'h000000, off});
	endfunction

	// Far forms carry a full data memory address
	function automatic logic op_far(input mcx_op_t op);
		op_far = (op >= OP_FA_ADC) && (op <= OP_FA_ZERO_BIT);
	endfunction

	// Table read forms
	function automatic logic op_table(input mcx_op_t op);
		op_table = (op >= OP_TB_PAGE) && (op <= OP_TB_LAST_INC);
	endfunction

	// Architectural state
	logic [7:0] acc_reg; // Accumulator
	logic [5:0] flags_reg; // Status flags
	logic [7:0] ptr_lo_reg; // Table pointer low
	logic [7:0] ptr_hi_reg; // Table pointer high
	logic [7:0] fetch_hi_reg; // Table read high latch
	logic [MCX_BANK_W-1:0] bank_reg; // Bank for non-far forms
	logic [31:0] opnd_reg; // Address, immediate, bit number
	mcx_op_t op_reg; // Instruction in flight
	logic bad_op_reg; // Last command was not a known code
	logic skip_reg; // Last instruction skipped
	logic [MCX_DM_AW-1:0] maddr_reg; // Software memory pointer
	mcx_state_t state_reg, state_next; // Sequencer

	// Bus slave state
	logic wr_pend_reg; // Write data phase this cycle
	logic [31:0] ap_addr_reg; // Captured address
	logic [1:0] rd_cnt_reg; // Read wait states left

	// Operand fields
	wire [MCX_DM_AW-1:0] opnd_addr = opnd_reg[MCX_OPND_ADDR_LSB +: MCX_DM_AW];
	wire [7:0] opnd_imm = opnd_reg[MCX_OPND_IMM_LSB +: 8];
	wire [2:0] opnd_bit = opnd_reg[MCX_OPND_BIT_LSB +: 3];
	wire busy = (state_reg != S_IDLE);

	// full address reach
	// Far forms ignore the bank; others are confined to one 256-byte bank
	wire [MCX_DM_AW-1:0] ex_addr = op_far(op_reg) ? opnd_addr : {bank_reg, opnd_addr[7:0]};

	// Data memory hookup
	logic [7:0] dm_rdata; // Byte read at the fetch edge
	logic dm_we; // Write strobe
	logic [7:0] dm_wdata; // Write byte
	wire [MCX_DM_AW-1:0] dm_addr = busy ? ex_addr : maddr_reg;

	// Bus address phase and register selects
	wire ap_take = hsel && htrans[1] && hready;
	wire sw_wr = wr_pend_reg;
	wire sel_acc = reg_hit(ap_addr_reg, MCX_OFF_ACC);
	wire sel_status = reg_hit(ap_addr_reg, MCX_OFF_STATUS);
	wire sel_ptr_lo = reg_hit(ap_addr_reg, MCX_OFF_PTR_LO);
	wire sel_ptr_hi = reg_hit(ap_addr_reg, MCX_OFF_PTR_HI);
	wire sel_fetch_hi = reg_hit(ap_addr_reg, MCX_OFF_FETCH_HI);
	wire sel_opnd = reg_hit(ap_addr_reg, MCX_OFF_OPND);
	wire sel_cmd = reg_hit(ap_addr_reg, MCX_OFF_CMD);
	wire sel_exst = reg_hit(ap_addr_reg, MCX_OFF_EXST);
	wire sel_maddr = reg_hit(ap_addr_reg, MCX_OFF_MADDR);
	wire sel_mdata = reg_hit(ap_addr_reg, MCX_OFF_MDATA);
	wire sel_bank = reg_hit(ap_addr_reg, MCX_OFF_BANK);
	// Datapath-owned registers only take software writes while idle
	wire sw_idle_wr = sw_wr && !busy;
	wire cmd_start = sw_idle_wr && sel_cmd;

	// Read data selection; unmapped reads return zero
	wire [31:0] rd_mux =
		sel_acc ? {24'h000000, acc_reg} :
		sel_status ? {26'h0, flags_reg} :
		sel_ptr_lo ? {24'h000000, ptr_lo_reg} :
		sel_ptr_hi ? {24'h000000, ptr_hi_reg} :
		sel_fetch_hi ? {24'h000000, fetch_hi_reg} :
		sel_opnd ? opnd_reg :
		sel_cmd ? {27'h0, op_reg} :
		sel_exst ? {29'h0, bad_op_reg, skip_reg, busy} :
		sel_maddr ? {21'h0, maddr_reg} :
		sel_mdata ? {24'h000000, dm_rdata} :
		sel_bank ? {29'h0, bank_reg} : 32'h00000000;

	// Arithmetic unit
	logic [7:0] au_res;
	logic au_c, au_half, au_wrap, au_z, au_sgn;
	wire au_sub = (op_reg == OP_DIFF_MEM) || (op_reg == OP_DIFF_IMM);
	wire au_adc = (op_reg == OP_FA_ADC) || (op_reg == OP_FA_ADC_MEM);
	wire au_cin = au_sub ? 1'b1 : (au_adc & flags_reg[MCX_FLG_C]);
	wire [7:0] au_b = (op_reg == OP_DIFF_IMM) ? opnd_imm : dm_rdata;

	mcx_addsub u_addsub (
		.a(acc_reg),
		.b(au_b),
		.cin(au_cin),
		.sub(au_sub),
		.res(au_res),
		.c(au_c),
		.half(au_half),
		.wrap(au_wrap),
		.z(au_z),
		.sgn(au_sgn)
	);

	mcx_dmem u_dmem (
		.hclk(hclk),
		.hresetn(hresetn),
		.we(dm_we),
		.addr(dm_addr),
		.wdata(dm_wdata),
		.rdata(dm_rdata)
	);

	// One-hot select of the bit number
	logic [7:0] bit_sel;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_bit
			assign bit_sel[gi] = (opnd_bit == 3'(gi));
		end
	endgenerate

	// Logic unit results
	wire [7:0] nib_val = {dm_rdata[3:0], dm_rdata[7:4]};
	wire [7:0] xr_val = acc_reg ^ ((op_reg == OP_XR_IMM) ? opnd_imm : dm_rdata);
	wire [7:0] and_val = acc_reg & dm_rdata;
	wire byte_zero = (dm_rdata == MCX_ZERO_BYTE);
	wire bit_zero = ((dm_rdata & bit_sel) == MCX_ZERO_BYTE);
	// carry means no borrow
	// Chained zero follows Z for a plain subtract
	wire [5:0] arith_flags = {au_z, au_sgn, au_wrap, au_z, au_half, au_c};

	// Per-instruction result, destination, flags and skip
	logic [7:0] ex_val; // Result byte
	logic ex_acc; // Result goes to ACC
	logic ex_mem; // Result goes to data memory
	logic [5:0] ex_fmask; // Flags this instruction changes
	logic [5:0] ex_fval; // New values of those flags
	logic ex_skip; // Skip the next instruction
	always_comb begin
		ex_val = au_res;
		ex_acc = 1'b0;
		ex_mem = 1'b0;
		ex_fmask = MCX_MASK_NONE;
		ex_fval = arith_flags;
		ex_skip = 1'b0;
		case (op_reg)
			OP_DIFF_MEM: begin
				ex_mem = 1'b1;
				ex_fmask = MCX_MASK_SUB;
			end
			OP_DIFF_IMM: begin
				ex_acc = 1'b1;
				ex_fmask = MCX_MASK_SUB;
			end
			OP_NIB_MEM: begin
				ex_val = nib_val;
				ex_mem = 1'b1;
			end
			OP_NIB_ACC: begin
				ex_val = nib_val;
				ex_acc = 1'b1;
			end
			OP_SKZ_BYTE: begin
				ex_val = dm_rdata;
				ex_mem = 1'b1;
				ex_skip = byte_zero;
			end
			OP_SKZ_COPY: begin
				ex_val = dm_rdata;
				ex_acc = 1'b1;
				ex_skip = byte_zero;
			end
			OP_SKZ_BIT: begin
				ex_skip = bit_zero;
			end
			OP_XR_ACC, OP_XR_IMM: begin
				ex_val = xr_val;
				ex_acc = 1'b1;
				ex_fmask = MCX_MASK_ZERO;
				ex_fval = {3'b000, xr_val == MCX_ZERO_BYTE, 2'b00};
			end
			OP_XR_MEM: begin
				ex_val = xr_val;
				ex_mem = 1'b1;
				ex_fmask = MCX_MASK_ZERO;
				ex_fval = {3'b000, xr_val == MCX_ZERO_BYTE, 2'b00};
			end
			OP_FA_ADC, OP_FA_ADD: begin
				ex_acc = 1'b1;
				ex_fmask = MCX_MASK_ADD;
			end
			OP_FA_ADC_MEM, OP_FA_ADD_MEM: begin
				ex_mem = 1'b1;
				ex_fmask = MCX_MASK_ADD;
			end
			OP_FA_AND: begin
				ex_val = and_val;
				ex_acc = 1'b1;
				ex_fmask = MCX_MASK_ZERO;
				ex_fval = {3'b000, and_val == MCX_ZERO_BYTE, 2'b00};
			end
			OP_FA_AND_MEM: begin
				ex_val = and_val;
				ex_mem = 1'b1;
				ex_fmask = MCX_MASK_ZERO;
				ex_fval = {3'b000, and_val == MCX_ZERO_BYTE, 2'b00};
			end
			OP_FA_ZERO: begin
				ex_val = MCX_ZERO_BYTE;
				ex_mem = 1'b1;
			end
			OP_FA_ZERO_BIT: begin
				ex_val = dm_rdata & ~bit_sel;
				ex_mem = 1'b1;
			end
			default: begin
				ex_val = au_res;
			end
		endcase
	end

	// Sequencer transitions
	wire in_exec = (state_reg == S_EXEC);
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: if (cmd_start) state_next = S_FETCH;
			S_FETCH: state_next = op_table(op_reg) ? S_TAB : S_EXEC;
			// One dummy cycle stands in for the skipped instruction
			S_EXEC: state_next = ex_skip ? S_SKIP : S_IDLE;
			S_TAB: state_next = S_TWAIT;
			S_TWAIT: state_next = S_TWR;
			S_TWR: state_next = S_IDLE;
			S_SKIP: state_next = S_IDLE;
			default: state_next = S_IDLE;
		endcase
	end

	// Memory write: executing datapath, else software through the data window
	wire tab_last = (op_reg == OP_TB_LAST) || (op_reg == OP_TB_LAST_INC);
	wire tab_inc = (op_reg == OP_TB_PAGE_INC) || (op_reg == OP_TB_LAST_INC);
	wire sw_mem_wr = sw_idle_wr && sel_mdata;
	wire tab_wr = (state_reg == S_TWR);
	assign dm_we = (in_exec && ex_mem) || tab_wr || sw_mem_wr;
	assign dm_wdata = tab_wr ? pm_rdata[7:0] : (busy ? ex_val : hwdata[7:0]);

	// Sequencer and status register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= S_IDLE;
			exec_busy <= 1'b0;
			exec_skip <= 1'b0;
		end else begin
			state_reg <= state_next;
			exec_busy <= (state_next != S_IDLE);
			exec_skip <= (state_next == S_SKIP);
		end
	end

	// Accumulator: software while idle, datapath when executing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_reg <= MCX_RST_BYTE;
		end else if (in_exec && ex_acc) begin
			acc_reg <= ex_val;
		end else if (sw_idle_wr && sel_acc) begin
			acc_reg <= hwdata[7:0];
		end
	end

	// untouched flags held
	// Only bits in the instruction's mask are replaced
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_reg <= MCX_RST_FLAGS;
		end else if (in_exec) begin
			flags_reg <= (flags_reg & ~ex_fmask) | (ex_fval & ex_fmask);
		end else if (sw_idle_wr && sel_status) begin
			flags_reg <= hwdata[5:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ptr_lo_reg <= MCX_RST_BYTE;
		end else if ((state_reg == S_FETCH) && tab_inc) begin
			ptr_lo_reg <= ptr_lo_reg + 8'h01;
		end else if (sw_idle_wr && sel_ptr_lo) begin
			ptr_lo_reg <= hwdata[7:0];
		end
	end

	// last page uses low pointer only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pm_addr <= 16'h0000;
			pm_rd <= 1'b0;
		end else begin
			if (state_reg == S_TAB) begin
				pm_addr <= {tab_last ? MCX_LAST_PAGE : ptr_hi_reg, ptr_lo_reg};
			end
			pm_rd <= (state_reg == S_TAB);
		end
	end

	// High byte of the fetched word lands in the latch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fetch_hi_reg <= MCX_RST_BYTE;
		end else if (tab_wr) begin
			fetch_hi_reg <= pm_rdata[15:8];
		end
	end

	// Software-owned configuration; command accepted only while idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ptr_hi_reg <= MCX_RST_BYTE;
			bank_reg <= '0;
			opnd_reg <= 32'h00000000;
			op_reg <= OP_NOP;
			bad_op_reg <= 1'b0;
			maddr_reg <= '0;
		end else begin
			if (sw_idle_wr && sel_ptr_hi) ptr_hi_reg <= hwdata[7:0];
			if (sw_idle_wr && sel_bank) bank_reg <= hwdata[MCX_BANK_W-1:0];
			if (sw_idle_wr && sel_opnd) opnd_reg <= hwdata;
			if (sw_wr && sel_maddr) maddr_reg <= hwdata[MCX_DM_AW-1:0];
			// Unknown codes run as a no-op and are flagged
			if (cmd_start) begin
				op_reg <= mcx_op_t'(hwdata[4:0]);
				bad_op_reg <= (hwdata[4:0] > OP_FA_ZERO_BIT);
			end
		end
	end

	// Skip result of the last instruction, readable after it ends
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			skip_reg <= 1'b0;
		end else if (cmd_start) begin
			skip_reg <= 1'b0;
		end else if (in_exec) begin
			skip_reg <= ex_skip;
		end
	end

	// Bus address phase capture; only word writes are honoured, reads of any size are served
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			ap_addr_reg <= 32'h00000000;
		end else begin
			wr_pend_reg <= ap_take && hwrite && (hsize == 3'b010);
			if (ap_take) ap_addr_reg <= haddr;
		end
	end

	// Reads take two wait states so the memory window sees a settled pointer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_cnt_reg <= 2'h0;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
			if (ap_take && !hwrite) begin
				rd_cnt_reg <= MCX_RD_WAIT;
				hreadyout <= 1'b0;
			end else if (rd_cnt_reg == 2'h1) begin
				rd_cnt_reg <= 2'h0;
				hrdata <= rd_mux;
				hreadyout <= 1'b1;
			end else if (rd_cnt_reg != 2'h0) begin
				rd_cnt_reg <= rd_cnt_reg - 2'h1;
			end
		end
	end
endmodule // mcx_exec
`default_nettype wire

//--- sim/mcx_pmem_model.sv
/*
 * Program memory partner: serves one word the cycle after the read strobe.
 * Assumes the datapath holds pm_addr while pm_rd is high.
 */
`timescale 1ns/1ps
`default_nettype none
module mcx_pmem_model (
	// Clock
	input wire logic hclk,
	// Read port
	input wire logic [15:0] pm_addr,
	input wire logic pm_rd,
	output logic [15:0] pm_rdata
);
	// Known start so the toggling idle pattern is defined
	initial pm_rdata = 16'h0000;
	// word per address
	// Outside a read the bus flips every cycle, so stale data never matches
	always @(posedge hclk) begin
		if (pm_rd) begin
			pm_rdata <= {pm_addr[7:0] ^ 8'h3C, pm_addr[15:8] + pm_addr[7:0]};
		end else begin
			pm_rdata <= ~pm_rdata;
		end
	end
endmodule // mcx_pmem_model
`default_nettype wire

//--- sim/mcx_exec_assertions.sv
/*
 * Port timing checker for the execute datapath.
 * Assumes one bus master with hready looped back from hreadyout.
 */
`timescale 1ns/1ps
`default_nettype none
module mcx_exec_assertions (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// Execution
	input wire logic pm_rd,
	input wire logic exec_busy,
	input wire logic exec_skip
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Accepted transfers
	wire logic rd_take = hsel & htrans[1] & hready & !hwrite;
	wire logic wr_take = hsel & htrans[1] & hready & hwrite;
	a_read_two_waits: assert property (rd_take |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
		else $error("read wait states wrong");
	a_write_no_wait: assert property (wr_take |=> hreadyout)
		else $error("write stalled");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_skip_in_busy: assert property (exec_skip |-> exec_busy && !pm_rd)
		else $error("skip outside an instruction");
	a_skip_one_cycle: assert property (exec_skip |=> !exec_skip && !exec_busy)
		else $error("dummy cycle not single");
	a_skip_after_exec: assert property (exec_skip |-> $past(exec_busy) && $past(exec_busy, 2))
		else $error("dummy cycle too early");
	a_fetch_pulse: assert property (pm_rd |-> exec_busy ##1 !pm_rd && exec_busy ##1 !exec_busy)
		else $error("table fetch timing wrong");
	a_busy_bounded: assert property ($rose(exec_busy) |-> ##[2:4] !exec_busy)
		else $error("instruction too long");
endmodule // mcx_exec_assertions
bind mcx_exec mcx_exec_assertions mcx_exec_assertions_inst (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .pm_rd(pm_rd), .exec_busy(exec_busy), .exec_skip(exec_skip));
`default_nettype wire

//--- sim/mcx_exec_test.sv
/*
 * Self-checking bench: random operands for every opcode, checked against
 * a behavioural model. Assumes the program memory partner alongside.
 */
`timescale 1ns/1ps
`default_nettype none
module mcx_exec_test;
	import mcx_pkg::*;
	// Bus and design signals
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pm_rd, exec_busy, exec_skip;
	logic [31:0] haddr, hwdata, hrdata, q, r, opn;
	logic [1:0] htrans;
	logic [2:0] hsize, bk, bt;
	logic [15:0] pm_addr, pm_rdata, w, pa;
	// Model state
	logic [7:0] a, m, tl, th, hl, imm, rs;
	logic [5:0] f;
	logic [8:0] s;
	logic [4:0] t;
	logic [10:0] ea;
	logic skp, vf, z;
	integer seed = 32'h9863;
	int failures, cmp_count, cyc, op, k, ns;
	mcx_exec mcx_exec_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pm_addr(pm_addr),
		.pm_rd(pm_rd), .pm_rdata(pm_rdata), .exec_busy(exec_busy), .exec_skip(exec_skip));
	mcx_pmem_model mcx_pmem_model_inst (.hclk(hclk), .pm_addr(pm_addr), .pm_rd(pm_rd),
		.pm_rdata(pm_rdata));
	// Clock at 25 ns
	initial begin
		hclk = 0;
		forever #12.5 hclk = ~hclk;
	end
	// Verdict and end of run
	task close_out;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Hang guard, well above the few thousand cycles needed
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			close_out;
		end
	end
	// Far-side strobe address and dummy cycles, seen as they stand at the edge
	always @(posedge hclk) begin
		if (pm_rd === 1'b1) pa = pm_addr;
		if (exec_skip === 1'b1) ns++;
	end
	// One single word transfer, waiting on hready in both phases
	task bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, ad};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	// Compare one register word
	task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// Main sequence
	initial begin
		hresetn = 0;
		hsel = 0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		hl = 8'h00;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, 8'h30, 0);
		cmp("unmapped", 0, q);
		bus(0, MCX_OFF_STATUS, 0);
		cmp("status reset", 0, q);
		// Every opcode, plus one undefined code
		for (op = 0; op < 24; op++) begin
			for (k = 0; k < 4; k++) begin
				r = $random(seed);
				opn = $random(seed) & 32'h07FF07FF;
				{a, f, bk} = {r[7:0], r[13:8], r[18:16]};
				m = (r[31:30] == 2'h0) ? 8'h00 : r[29:22];
				{tl, th} = 16'($random(seed));
				imm = opn[23:16];
				bt = opn[26:24];
				ea = (op >= 15 && op <= 22) ? opn[10:0] : {bk, opn[7:0]};
				bus(1, MCX_OFF_ACC, a);
				bus(1, MCX_OFF_STATUS, f);
				bus(1, MCX_OFF_OPND, opn);
				bus(1, MCX_OFF_BANK, bk);
				bus(1, MCX_OFF_PTR_LO, tl);
				bus(1, MCX_OFF_PTR_HI, th);
				bus(1, MCX_OFF_MADDR, ea);
				bus(1, MCX_OFF_MDATA, m);
				ns = 0;
				pa = 'x;
				bus(1, MCX_OFF_CMD, op);
				do bus(0, MCX_OFF_EXST, 0); while (q[0] !== 1'b0);
				skp = 0;
				case (op)
					1, 2: begin
						w[7:0] = (op == 1) ? m : imm;
						s = {1'b0, a} - {1'b0, w[7:0]};
						rs = s[7:0];
						vf = (a[7] ^ w[7]) & (rs[7] ^ a[7]);
						z = (rs == 8'h00);
						f = {z, vf ^ rs[7], vf, z, a[3:0] >= w[3:0], !s[8]};
						if (op == 1) m = rs; else a = rs;
					end
					3: m = {m[3:0], m[7:4]};
					4: a = {m[3:0], m[7:4]};
					5: skp = (m == 8'h00);
					6: begin a = m; skp = (m == 8'h00); end
					7: skp = !m[bt];
					8, 9, 10, 11: begin
						if (op >= 10) tl = tl + 8'h01;
						w = {(op % 2) ? MCX_LAST_PAGE : th, tl};
						{hl, m} = {w[7:0] ^ 8'h3C, w[15:8] + w[7:0]};
					end
					12: begin a = a ^ m; f[2] = (a == 8'h00); end
					13: begin m = a ^ m; f[2] = (m == 8'h00); end
					14: begin a = a ^ imm; f[2] = (a == 8'h00); end
					15, 16, 17, 18: begin
						s = a + m + (op < 17 ? f[0] : 1'b0);
						t = a[3:0] + m[3:0] + (op < 17 ? f[0] : 1'b0);
						rs = s[7:0];
						vf = !(a[7] ^ m[7]) & (rs[7] ^ a[7]);
						f[4:0] = {vf ^ rs[7], vf, rs == 8'h00, t[4], s[8]};
						if (op % 2 == 0) m = rs; else a = rs;
					end
					19: begin a = a & m; f[2] = (a == 8'h00); end
					20: begin m = a & m; f[2] = (m == 8'h00); end
					21: m = 8'h00;
					22: m[bt] = 1'b0;
					default: ;
				endcase
				bus(0, MCX_OFF_ACC, 0);
				cmp("acc", a, q);
				bus(0, MCX_OFF_STATUS, 0);
				cmp("status", f, q);
				bus(0, MCX_OFF_MDATA, 0);
				cmp("data byte", m, q);
				bus(0, MCX_OFF_PTR_LO, 0);
				cmp("pointer low", tl, q);
				bus(0, MCX_OFF_FETCH_HI, 0);
				cmp("fetch high", hl, q);
				bus(0, MCX_OFF_EXST, 0);
				cmp("exst", {op > 22, skp}, q[2:1]);
				cmp("skip pulses", skp, ns);
				if (op >= 8 && op <= 11) cmp("table address", w, pa);
			end
		end
		close_out;
	end
endmodule // mcx_exec_test
`default_nettype wire
